/* verilog/ex3_alu.sv */
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ex3_cfg.svh"
module ex3_alu
   import ex3_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   ex3_if.dev bus,
   output logic [31:0] mq_value
);

   logic [31:0] bcd_q;
   logic [31:0] mq_q;
   logic [31:0] mq_d;
   logic [31:0] y_q;
   logic [3:0] y_oe_q;
   logic zero_q;
   logic neg_q;
   logic ovr_q;
   logic cy_q;
   logic ssf_q;

   ex3_instr_type op;
   logic [3:0] sel;
   logic [3:0] sel_eff;
   logic word_op;
   logic known_op;
   logic add_op;
   ex3_sum_type r;
   logic [31:0] res;
   logic [31:0] ymux;
   logic [4:0] top;
   logic alu_c;
   logic alu_v;

   // Adder cut into segments; each segment starts from the given carry
   function automatic ex3_sum_type seg_add(
      input logic [31:0] a,
      input logic [31:0] b,
      input logic cin,
      input int seg
   );
      ex3_sum_type t;
      logic c;
      t = '0;
      c = cin;
      for (int i = 0; i < 32; i++) begin
         if (i % seg == 0) begin
            c = cin;
         end
         t.sum[i] = a[i] ^ b[i] ^ c;
         t.cv[i] = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
         c = t.cv[i];
      end
      return t;
   endfunction : seg_add

   function automatic logic [1:0] top_byte(input logic [3:0] s);
      logic [1:0] t;
      t = 2'h0;
      for (int k = 0; k < 4; k++) begin
         if (s[k]) begin
            t = 2'(k);
         end
      end
      return t;
   endfunction : top_byte

   // Nibble carry kept from the add picks +3 or -3; the top nibble rebuilds its carry from the prior overflow
   function automatic logic [31:0] corr_const(
      input logic [31:0] bcd,
      input logic [3:0] s,
      input logic pov
   );
      logic [31:0] k;
      logic up;
      k = '0;
      for (int n = 0; n < 8; n++) begin
         up = bcd[4 * n + 3];
         if (n == 2 * int'(top_byte(s)) + 1) begin
            up = bcd[4 * n + 2] ^ pov;
         end
         k[4 * n +: 4] = up ? `EX3_CORR_UP : `EX3_CORR_DN;
      end
      return k;
   endfunction : corr_const

   function automatic logic [31:0] merge(
      input logic [31:0] v,
      input logic [31:0] s,
      input logic [3:0] m
   );
      logic [31:0] o;
      o = s;
      for (int k = 0; k < 4; k++) begin
         if (m[k]) begin
            o[8 * k +: 8] = v[8 * k +: 8];
         end
      end
      return o;
   endfunction : merge

   assign op = bus.instr;
   assign sel = ~bus.byte_select_n;
   assign word_op = (op == `EX3_OP_WADD) || (op == `EX3_OP_WSUB) || (op == `EX3_OP_WCORR);
   assign add_op = (op == `EX3_OP_WADD) || (op == `EX3_OP_WSUB) || (op == `EX3_OP_BYTE_ADD);
   assign known_op = word_op || (op == `EX3_OP_BYTE_ADD) || (op == `EX3_OP_BCORR) || (op == `EX3_OP_DUMP);
   assign sel_eff = word_op ? `EX3_ALL_BYTES : sel;
   assign top = {top_byte(sel_eff), 3'h7};

   always_comb begin
      case (op)
         `EX3_OP_WADD: begin
            r = seg_add(bus.s_bus, bus.r_bus, bus.carry_in, `EX3_SEG_WORD);
         end
         `EX3_OP_WSUB: begin
            r = seg_add(bus.s_bus, ~bus.r_bus, bus.carry_in, `EX3_SEG_WORD);
         end
         `EX3_OP_BYTE_ADD: begin
            r = seg_add(bus.s_bus, bus.r_bus, 1'b0, `EX3_SEG_BYTE);
         end
         `EX3_OP_BCORR: begin
            r = seg_add(bus.s_bus, corr_const(bcd_q, sel_eff, ssf_q), 1'b0, `EX3_SEG_NIB);
         end
         `EX3_OP_WCORR: begin
            r = seg_add(bus.s_bus, corr_const(bcd_q, sel_eff, ssf_q), 1'b0, `EX3_SEG_NIB);
         end
         default: begin
            r = '0;
         end
      endcase
   end

   // Byte ops keep S in unselected bytes; word ops replace all bytes
   assign res = merge(r.sum, bus.s_bus, sel_eff);
   assign alu_c = (|sel_eff) & r.cv[top];
   assign alu_v = (|sel_eff) & (r.cv[top] ^ r.cv[top - 5'h1]);

   // Flag dump loads MQ from the flops; Y mux then takes MQ unchanged
   assign mq_d = (op == `EX3_OP_DUMP) ? bcd_q : mq_q;
   assign ymux = bus.y_source_select ? mq_d : res;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mq_q <= '0;
      end else begin
         mq_q <= mq_d;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         y_q <= '0;
      end else if (known_op) begin
         y_q <= ymux;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         y_oe_q <= '0;
      end else begin
         y_oe_q <= {4{~bus.y_output_enable_n}};
      end
   end

   // Add and subtract leave their bit carries behind for the correction step
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bcd_q <= '0;
      end else if (add_op) begin
         bcd_q <= r.cv;
      end
   end

   // Overflow reported by an add feeds the next correction
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ssf_q <= 1'b0;
      end else if (add_op) begin
         ssf_q <= alu_v;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         zero_q <= 1'b0;
         neg_q <= 1'b0;
         ovr_q <= 1'b0;
         cy_q <= 1'b0;
      end else begin
         case (op)
            `EX3_OP_BCORR: begin
               zero_q <= 1'b0;
               neg_q <= 1'b0;
               ovr_q <= alu_v;
               cy_q <= alu_c;
            end
            `EX3_OP_WCORR: begin
               zero_q <= 1'b0;
               neg_q <= res[31];
               ovr_q <= alu_v;
               cy_q <= alu_c;
            end
            `EX3_OP_DUMP: begin
               zero_q <= 1'b0;
               neg_q <= 1'b0;
               ovr_q <= 1'b0;
               cy_q <= 1'b0;
            end
            `EX3_OP_WADD, `EX3_OP_WSUB, `EX3_OP_BYTE_ADD: begin
               zero_q <= (res == '0);
               neg_q <= res[top];
               ovr_q <= alu_v;
               cy_q <= alu_c;
            end
            default: begin
               zero_q <= zero_q;
            end
         endcase
      end
   end

   assign bus.y = y_q;
   assign bus.y_oe = y_oe_q;
   assign bus.zero = zero_q;
   assign bus.neg = neg_q;
   assign bus.overflow_flag = ovr_q;
   assign bus.carry_in_out = cy_q;
   assign bus.shift_status_overflow_pin = ssf_q;
   assign mq_value = mq_q;

endmodule : ex3_alu

/* verilog/ex3_cfg.svh */
`ifndef EX3_CFG_SVH
`define EX3_CFG_SVH
// Overview of operation
// - Flag dump puts BCD flops in MQ and on Y
// - Dump routes flops via MQ to Y mux
// - Dump is the only way to read flops
// - Controller follows byte add with byte correction
// - Byte correction adds S to flop-chosen constant
// - Selected bytes produce corrected excess-3 value
// - Unselected bytes pass S unchanged
// - Byte correction: zero, negative 0; overflow, carry
// - Controller follows word add with word correction
// - Word correction adds flop-chosen constant, whole word
// - Word correction: zero 0, negative MSB, overflow, carry
// - Word BCD add biases all bytes by 33h
// - Bias removed by subtraction after correction
// - Byte BCD add biases selected bytes only
`define EX3_OP_DUMP 8'h5f
`define EX3_OP_BCORR 8'h8f
`define EX3_OP_WCORR 8'h9f
`define EX3_OP_WADD 8'hf1
`define EX3_OP_WSUB 8'hf2
`define EX3_OP_BYTE_ADD 8'h88
`define EX3_OP_IDLE 8'h00
`define EX3_BIAS 8'h33
`define EX3_CORR_UP 4'h3
`define EX3_CORR_DN 4'hd
`define EX3_SEG_WORD 32
`define EX3_SEG_BYTE 8
`define EX3_SEG_NIB 4
`define EX3_ALL_BYTES 4'hf
`define EX3_REG_CTRL 8'h00
`define EX3_REG_OPA 8'h04
`define EX3_REG_OPB 8'h08
`define EX3_REG_BSEL 8'h0c
`define EX3_REG_RESULT 8'h10
`define EX3_REG_FLAGS 8'h14
`define EX3_REG_ISTAT 8'h18
`define EX3_REG_IMASK 8'h1c
`define EX3_CMD_WBCD 2'h0
`define EX3_CMD_BBCD 2'h1
`define EX3_CMD_DUMP 2'h2
`endif

/* verilog/ex3_pkg.sv */
package ex3_pkg;
   typedef logic [7:0] ex3_instr_type;
   typedef struct packed {
      logic [31:0] sum;
      logic [31:0] cv;
   } ex3_sum_type;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADD_EX, ST_ADD_CAP, ST_COR_EX, ST_COR_CAP, ST_DMP_EX, ST_DMP_CAP
   } ex3_state_type;
endpackage : ex3_pkg

/* verilog/ex3_if.sv */
`timescale 1ns/1ps
interface ex3_if;
   logic [7:0] instr;
   logic [31:0] s_bus;
   logic [31:0] r_bus;
   logic [3:0] byte_select_n;
   logic carry_in;
   logic y_output_enable_n;
   logic y_source_select;
   logic [31:0] y;
   logic [3:0] y_oe;
   logic zero;
   logic neg;
   logic overflow_flag;
   logic carry_in_out;
   logic shift_status_overflow_pin;
   modport dev (
      input instr, s_bus, r_bus, byte_select_n, carry_in, y_output_enable_n, y_source_select,
      output y, y_oe, zero, neg, overflow_flag, carry_in_out, shift_status_overflow_pin
   );
   modport ctl (
      output instr, s_bus, r_bus, byte_select_n, carry_in, y_output_enable_n, y_source_select,
      input y, y_oe, zero, neg, overflow_flag, carry_in_out, shift_status_overflow_pin
   );
endinterface : ex3_if

/* verilog/ex3_ctrl.sv */
`timescale 1ns/1ps
`include "ex3_cfg.svh"
module ex3_ctrl
   import ex3_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   ex3_if.ctl bus,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);

   ex3_state_type st_q;
   logic [7:0] instr_q;
   logic [31:0] s_q;
   logic [31:0] r_q;
   logic ysel_q;
   logic [1:0] cmd_q;
   logic [31:0] opa_q;
   logic [31:0] opb_q;
   logic [3:0] bsel_q;
   logic [31:0] result_q;
   logic [1:0] istat_q;
   logic [1:0] imask_q;
   logic [1:0] ev;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic wr;
   logic go;
   logic [3:0] mask;
   logic mapped;
   logic [31:0] rd;

   // Adds or removes the excess-3 bias in the masked bytes
   function automatic logic [31:0] bias(
      input logic [31:0] v,
      input logic [3:0] m,
      input logic sub
   );
      logic [31:0] o;
      o = v;
      for (int k = 0; k < 4; k++) begin
         if (m[k]) begin
            o[8 * k +: 8] = sub ? v[8 * k +: 8] - `EX3_BIAS : v[8 * k +: 8] + `EX3_BIAS;
         end
      end
      return o;
   endfunction : bias

   assign wr = psel & penable & pready_q & pwrite;
   assign go = wr && (paddr == `EX3_REG_CTRL) && pwdata[0] && (st_q == ST_IDLE);
   assign mask = (cmd_q == `EX3_CMD_WBCD) ? `EX3_ALL_BYTES : bsel_q;

   always_comb begin
      mapped = 1'b1;
      case (paddr)
         `EX3_REG_CTRL: rd = {29'h0, cmd_q, 1'b0};
         `EX3_REG_OPA: rd = opa_q;
         `EX3_REG_OPB: rd = opb_q;
         `EX3_REG_BSEL: rd = {28'h0, bsel_q};
         `EX3_REG_RESULT: rd = result_q;
         `EX3_REG_FLAGS: rd = {26'h0, st_q != ST_IDLE, bus.shift_status_overflow_pin,
                               bus.carry_in_out, bus.overflow_flag, bus.neg, bus.zero};
         `EX3_REG_ISTAT: rd = {30'h0, istat_q};
         `EX3_REG_IMASK: rd = {30'h0, imask_q};
         default: begin
            rd = '0;
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pready_q <= 1'b0;
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel & ~penable;
         if (psel & ~penable) begin
            prdata_q <= pwrite ? 32'h0 : rd;
            pslverr_q <= ~mapped;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_q <= '0;
         opa_q <= '0;
         opb_q <= '0;
         bsel_q <= '0;
         imask_q <= '0;
      end else if (wr) begin
         case (paddr)
            `EX3_REG_CTRL: if (st_q == ST_IDLE) cmd_q <= pwdata[2:1];
            `EX3_REG_OPA: opa_q <= pwdata;
            `EX3_REG_OPB: opb_q <= pwdata;
            `EX3_REG_BSEL: bsel_q <= pwdata[3:0];
            `EX3_REG_IMASK: imask_q <= pwdata[1:0];
            default: imask_q <= imask_q;
         endcase
      end
   end

   // Event in the clearing cycle survives the write-one-to-clear
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         istat_q <= '0;
      end else begin
         istat_q <= (istat_q & ~((wr && paddr == `EX3_REG_ISTAT) ? pwdata[1:0] : 2'h0)) | ev;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(istat_q & imask_q);
      end
   end

   assign ev = {(st_q == ST_COR_CAP) & bus.overflow_flag, (st_q == ST_COR_CAP) | (st_q == ST_DMP_CAP)};

   // Instruction stands one cycle; the device answer is taken two edges later
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
         instr_q <= `EX3_OP_IDLE;
         s_q <= '0;
         r_q <= '0;
         ysel_q <= 1'b0;
         result_q <= '0;
      end else begin
         instr_q <= `EX3_OP_IDLE;
         case (st_q)
            ST_IDLE: begin
               ysel_q <= 1'b0;
               if (go && pwdata[2:1] == `EX3_CMD_DUMP) begin
                  instr_q <= `EX3_OP_DUMP;
                  ysel_q <= 1'b1;
                  st_q <= ST_DMP_EX;
               end else if (go) begin
                  instr_q <= (pwdata[2:1] == `EX3_CMD_WBCD) ? `EX3_OP_WADD : `EX3_OP_BYTE_ADD;
                  s_q <= bias(opa_q, (pwdata[2:1] == `EX3_CMD_WBCD) ? `EX3_ALL_BYTES : bsel_q, 1'b0);
                  r_q <= bias(opb_q, (pwdata[2:1] == `EX3_CMD_WBCD) ? `EX3_ALL_BYTES : bsel_q, 1'b0);
                  st_q <= ST_ADD_EX;
               end
            end
            ST_ADD_EX: st_q <= ST_ADD_CAP;
            ST_ADD_CAP: begin
               instr_q <= (cmd_q == `EX3_CMD_WBCD) ? `EX3_OP_WCORR : `EX3_OP_BCORR;
               s_q <= bus.y;
               st_q <= ST_COR_EX;
            end
            ST_COR_EX: st_q <= ST_COR_CAP;
            ST_COR_CAP: begin
               result_q <= bias(bus.y, mask, 1'b1);
               st_q <= ST_IDLE;
            end
            ST_DMP_EX: st_q <= ST_DMP_CAP;
            ST_DMP_CAP: begin
               result_q <= bus.y;
               ysel_q <= 1'b0;
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   assign bus.instr = instr_q;
   assign bus.s_bus = s_q;
   assign bus.r_bus = r_q;
   assign bus.byte_select_n = ~mask;
   assign bus.carry_in = 1'b0;
   assign bus.y_output_enable_n = 1'b0;
   assign bus.y_source_select = ysel_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

endmodule : ex3_ctrl

/* testbench/ex3_properties.sv */
`timescale 1ns/1ps
`include "ex3_cfg.svh"
module ex3_properties (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] instr,
   input wire logic [31:0] s_bus,
   input wire logic [3:0] byte_select_n,
   input wire logic y_source_select,
   input wire logic [31:0] y,
   input wire logic zero,
   input wire logic neg,
   input wire logic overflow_flag,
   input wire logic carry_in_out,
   input wire logic [31:0] mq_value
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // A corrected nibble differs from its input by +3 or -3, modulo 16
   function automatic logic nib_ok(input logic [3:0] a, input logic [3:0] b);
      return ((a - b) == `EX3_CORR_UP) || ((a - b) == `EX3_CORR_DN);
   endfunction : nib_ok

   a_dump_flags_clear: assert property (
      instr == `EX3_OP_DUMP |=> !zero && !neg && !overflow_flag && !carry_in_out)
      else $error("dump left a status flag set");
   a_dump_y_mq: assert property (instr == `EX3_OP_DUMP && y_source_select |=> y == mq_value)
      else $error("dump output differs from mq");
   a_mq_only_dump: assert property (instr != `EX3_OP_DUMP |=> $stable(mq_value))
      else $error("mq changed outside a dump");
   a_bcorr_flags_low: assert property (instr == `EX3_OP_BCORR |=> !zero && !neg)
      else $error("byte correction left zero or negative set");
   a_bcorr_pass_b0: assert property (
      instr == `EX3_OP_BCORR && byte_select_n[0] |=> y[7:0] == $past(s_bus[7:0]))
      else $error("unselected byte 0 altered");
   a_bcorr_pass_b3: assert property (
      instr == `EX3_OP_BCORR && byte_select_n[3] |=> y[31:24] == $past(s_bus[31:24]))
      else $error("unselected byte 3 altered");
   a_bcorr_nib_adj: assert property (
      instr == `EX3_OP_BCORR && !byte_select_n[0] |=> nib_ok(y[3:0], $past(s_bus[3:0])))
      else $error("selected nibble not adjusted by three");
   a_wcorr_zero_low: assert property (instr == `EX3_OP_WCORR |=> !zero)
      else $error("word correction left zero set");
   a_wcorr_neg_msb: assert property (instr == `EX3_OP_WCORR |=> neg == y[31])
      else $error("word correction negative flag wrong");
   a_wcorr_whole_word: assert property (
      instr == `EX3_OP_WCORR |=> nib_ok(y[3:0], $past(s_bus[3:0])) && nib_ok(y[31:28], $past(s_bus[31:28])))
      else $error("word correction nibble not adjusted");

   c_dump: cover property (instr == `EX3_OP_DUMP && y_source_select);
   c_bcorr_part: cover property (instr == `EX3_OP_BCORR && byte_select_n != 4'hf && byte_select_n != 4'h0);
   c_wcorr: cover property (instr == `EX3_OP_WCORR);
endmodule : ex3_properties

/* testbench/ex3_bench.sv */
`timescale 1ns/1ps
`include "ex3_cfg.svh"
module excess3_bcd_correct_and_flag_dump_bench;
   logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, mq_value, last_flags;
   logic [3:0] seen_sel;
   logic seen_ysel;
   int num_errors = 0;
   int comparisons = 0;
   logic [31:0] wa [4] = '{32'h00001234, 32'h00000000, 32'h40000000, 32'h00000999};
   logic [31:0] wb [4] = '{32'h00005678, 32'h00000000, 32'h40000000, 32'h00000001};
   logic [31:0] ws [4] = '{32'h00006912, 32'h00000000, 32'h80000000, 32'h00001000};
   logic [3:0] bs [4] = '{4'h3, 4'h0, 4'hf, 4'h8};
   logic [31:0] ba [4] = '{32'h77001234, 32'h12345678, 32'h12345678, 32'h45aabbcc};
   logic [31:0] bb [4] = '{32'h77005678, 32'h12345678, 32'h11111111, 32'h54aabbcc};
   logic [31:0] bx [4] = '{32'h77006812, 32'h12345678, 32'h23456789, 32'h99aabbcc};
   // Carry and overflow left by each byte correction
   logic [1:0] bf [4] = '{2'h2, 2'h0, 2'h3, 2'h2};

   ex3_if link ();
   ex3_alu u_ex3_alu (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(link.dev), .mq_value(mq_value));
   ex3_ctrl u_ex3_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(link.ctl), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq));
   ex3_properties u_ex3_properties (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr(link.instr),
      .s_bus(link.s_bus), .byte_select_n(link.byte_select_n), .y_source_select(link.y_source_select),
      .y(link.y), .zero(link.zero), .neg(link.neg), .overflow_flag(link.overflow_flag),
      .carry_in_out(link.carry_in_out), .mq_value(mq_value));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Watch the link pins while a byte correction or dump is on the wire
   always @(negedge clk_sys) begin
      if (link.instr === `EX3_OP_BCORR) begin
         seen_sel <= link.byte_select_n;
      end
      if (link.instr === `EX3_OP_DUMP) begin
         seen_ysel <= link.y_source_select;
      end
   end

   task automatic test_done;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            num_errors++;
            test_done();
         end
         @(posedge clk_sys);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 32'h0, d, e);
   endtask : rd

   task automatic run_op(input logic [1:0] cmd, input logic [31:0] a, input logic [31:0] b, input logic [3:0] sel,
      output logic [31:0] res);
      int n;
      n = 0;
      wr(`EX3_REG_OPA, a);
      wr(`EX3_REG_OPB, b);
      wr(`EX3_REG_BSEL, {28'h0, sel});
      wr(`EX3_REG_CTRL, {29'h0, cmd, 1'b1});
      rd(`EX3_REG_FLAGS, last_flags);
      while (last_flags[5] !== 1'b0) begin
         n++;
         if (n > 50) begin
            num_errors++;
            test_done();
         end
         rd(`EX3_REG_FLAGS, last_flags);
      end
      rd(`EX3_REG_RESULT, res);
   endtask : run_op

   task automatic chk_irq(input logic exp);
      @(negedge clk_sys);
      chk_bit("irq", exp, irq);
      @(posedge clk_sys);
   endtask : chk_irq

   initial begin
      logic [31:0] v;
      logic e;
      logic [31:0] ex3;
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rd(`EX3_REG_FLAGS, v);
      chk_word("flags after reset", 32'h0, v);
      chk_bit("irq after reset", 1'b0, irq);
      chk_word("y drive enables", {28'h0, `EX3_ALL_BYTES}, {28'h0, link.y_oe});
      run_op(`EX3_CMD_DUMP, 32'h0, 32'h0, 4'h0, v);
      chk_word("dump after reset", 32'h0, v);
      chk_bit("dump mq path select", 1'b1, seen_ysel);
      $display("test reset_dump finished");
      for (int i = 0; i < 4; i++) begin
         ex3 = ws[i] + 32'h33333333;
         run_op(`EX3_CMD_WBCD, wa[i], wb[i], 4'h5, v);
         chk_word("word bcd result", ws[i], v);
         chk_bit("word zero flag", 1'b0, last_flags[0]);
         chk_bit("word negative flag", ex3[31], last_flags[1]);
         chk_bit("word carry flag", 1'b1, last_flags[3]);
         chk_bit("word overflow flag", 1'b0, last_flags[2]);
      end
      $display("test word_bcd finished");
      for (int i = 0; i < 4; i++) begin
         run_op(`EX3_CMD_BBCD, ba[i], bb[i], bs[i], v);
         chk_word("byte bcd result", bx[i], v);
         chk_word("byte select pins", {28'h0, ~bs[i]}, {28'h0, seen_sel});
         chk_bit("byte zero flag", 1'b0, last_flags[0]);
         chk_bit("byte negative flag", 1'b0, last_flags[1]);
         chk_word("byte carry and overflow", {30'h0, bf[i]}, {30'h0, last_flags[3:2]});
      end
      $display("test byte_bcd finished");
      rd(`EX3_REG_ISTAT, v);
      chk_word("done and overflow status", 32'h3, v);
      chk_irq(1'b0);
      wr(`EX3_REG_IMASK, 32'h1);
      chk_irq(1'b1);
      wr(`EX3_REG_ISTAT, 32'h3);
      chk_irq(1'b0);
      rd(`EX3_REG_ISTAT, v);
      chk_word("status after clear", 32'h0, v);
      run_op(`EX3_CMD_DUMP, 32'h0, 32'h0, 4'h0, v);
      chk_irq(1'b1);
      wr(`EX3_REG_ISTAT, 32'h3);
      $display("test interrupt finished");
      apb(1'b0, 8'h20, 32'h0, v, e);
      chk_bit("unmapped error", 1'b1, e);
      chk_word("unmapped data", 32'h0, v);
      rd(`EX3_REG_RESULT, ex3);
      wr(`EX3_REG_RESULT, ~ex3);
      rd(`EX3_REG_RESULT, v);
      chk_word("result read only", ex3, v);
      $display("test bus_access finished");
      test_done();
   end
endmodule : excess3_bcd_correct_and_flag_dump_bench
